// ---- rlm_regs.svh ----
`ifndef RLM_REGS_SVH
`define RLM_REGS_SVH

// APB byte offsets
`define RLM_CTRL_ADDR 12'h000
`define RLM_STATUS_ADDR 12'h004
`define RLM_OVP_CMD_ADDR 12'h008
`define RLM_VSET_ADDR 12'h00C
`define RLM_ISET_ADDR 12'h010
`define RLM_EVENT_ADDR 12'h014
`define RLM_DELAY_ADDR 12'h018
`define RLM_FLAGS_ADDR 12'h01C

// event register bits (write 1 = command pulse)
`define RLM_EV_GTL 0
`define RLM_EV_LLO 1
`define RLM_EV_CMD 2
`define RLM_EV_DCL 3

// control register bits
`define RLM_CTRL_OUT_ON 0
`define RLM_CTRL_FOLDBACK_PROTECTION 1
`define RLM_CTRL_HOLD 2
`define RLM_CTRL_SRQ 3
`define RLM_CTRL_AUX_OUTPUT_A 4
`define RLM_CTRL_AUX_OUTPUT_B 5

// status register bits
`define RLM_ST_REMOTE 0
`define RLM_ST_LLO 1
`define RLM_ST_OVP_SW 2
`define RLM_ST_OUT_EN 3
`define RLM_ST_SHDN 4
`define RLM_ST_REN 5
`define RLM_ST_STRAP 6

// power-on defaults
`define RLM_CTRL_RESET 6'h01
`define RLM_DELAY_MS 500
`define RLM_OVP_PERCENT 110
`define RLM_PERCENT_FULL 100
`define RLM_DELAY_TICK_MS 1
`define RLM_BOOT_WAIT 2'h2

`endif

// ---- rlm_pkg.sv ----
package rlm_pkg;
    typedef enum logic [1:0] {
        RLM_LOCAL = 2'h0,
        RLM_REMOTE = 2'h1,
        RLM_REMOTE_LOCKED = 2'h3
    } rlm_mode_t;
endpackage

// ---- rlm_sync_if.sv ----
`timescale 1ns/1ns
interface rlm_sync_if;
    logic startup_mode_select;
    logic remote_enable;
    logic shutdown_in;
    modport src (output startup_mode_select, output remote_enable, output shutdown_in);
    modport dst (input startup_mode_select, input remote_enable, input shutdown_in);
endinterface

// ---- rlm_sync.sv ----
`timescale 1ns/1ns
module rlm_sync
    import rlm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic startup_mode_select_pin,
    input wire logic remote_enable_pin,
    input wire logic shutdown_pin,
    rlm_sync_if.src sync
);
    logic [2:0] stage1;
    logic [2:0] stage2;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= 3'h0;
            stage2 <= 3'h0;
        end else begin
            stage1 <= {shutdown_pin, remote_enable_pin, startup_mode_select_pin};
            stage2 <= stage1;
        end
    end

    assign sync.startup_mode_select = stage2[0];
    assign sync.remote_enable = stage2[1];
    assign sync.shutdown_in = stage2[2];
endmodule

// ---- rlm_top.sv ----
// How it works
// R1: switch 0 starts remote, 1 starts local
// R2: remote indicator lit while in remote
// R3: remote startup zeroes levels, ovp 110 percent
// R4: remote startup loads remaining documented defaults
// R5: local button, gtl or ren drop go local
// R6: lockout makes local button ignored
// R7: ren plus any command enters remote
// R8: entering remote from local turns output off; a ctrl write that enters remote loads its written output bit instead
// R9: local mode uses front panel levels
// R10: gtl returns local even under lockout
// R11: only ren drop clears lockout, goes local
// R12: remote ovp from command, local from pot
// R13: jumpers decide ovp ownership
// R14: shutdown disables output without power down
// R15: polarity jumper selects active shutdown level
// R16: device clear restores power-on defaults
// R17: switch, ren and shutdown inputs synchronised, switch sampled after reset
// R18: mode and lockout cleared by reset
`timescale 1ns/1ns
`include "rlm_regs.svh"
module rlm_top
    import rlm_pkg::*;
#(
    parameter int LEVEL_W = 16,
    parameter int CLK_KHZ = 125000,
    parameter logic [LEVEL_W-1:0] MODEL_VOLTAGE_MAX = 16'h7FFF,
    parameter logic [LEVEL_W-1:0] MODEL_CURRENT_MAX = 16'h7FFF
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic startup_mode_select,
    input wire logic remote_enable,
    input wire logic local_button,
    input wire logic local_ovp_jumper,
    input wire logic remote_ovp_jumper,
    input wire logic shutdown_polarity_jumper,
    input wire logic shutdown_in,
    input wire logic [LEVEL_W-1:0] panel_voltage,
    input wire logic [LEVEL_W-1:0] panel_current,
    input wire logic [LEVEL_W-1:0] panel_ovp,
    output logic remote_indicator,
    output logic output_enable,
    output logic [LEVEL_W-1:0] voltage_level,
    output logic [LEVEL_W-1:0] current_level,
    output logic [LEVEL_W-1:0] ovp_level,
    output logic [LEVEL_W-1:0] soft_voltage_limit,
    output logic [LEVEL_W-1:0] soft_current_limit,
    output logic [15:0] protection_delay,
    output logic foldback_protection,
    output logic hold_mode,
    output logic service_request_enable,
    output logic aux_output_a,
    output logic aux_output_b
);
    localparam logic [15:0] DELAY_DEFAULT = 16'(`RLM_DELAY_MS / `RLM_DELAY_TICK_MS);

    function automatic logic [LEVEL_W-1:0] ovp_default(input logic [LEVEL_W-1:0] model_voltage_max);
        logic [LEVEL_W+7:0] scaled;
        scaled = (LEVEL_W+8)'(model_voltage_max) * (LEVEL_W+8)'(`RLM_OVP_PERCENT);
        return LEVEL_W'(scaled / (LEVEL_W+8)'(`RLM_PERCENT_FULL));
    endfunction

    // one place decides where each level comes from
    function automatic logic [LEVEL_W-1:0] pick_level(
        input logic from_sw,
        input logic [LEVEL_W-1:0] sw_val,
        input logic [LEVEL_W-1:0] panel_val
    );
        return from_sw ? sw_val : panel_val;
    endfunction

    function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] target);
        return addr == target;
    endfunction

    rlm_sync_if sync ();

    rlm_sync u_sync (
        .clk(clk),
        .rst(rst),
        .startup_mode_select_pin(startup_mode_select),
        .remote_enable_pin(remote_enable),
        .shutdown_pin(shutdown_in),
        .sync(sync)
    );

    // startup strap capture after reset release
    logic [1:0] boot_cnt;
    logic booted;
    // two synchroniser stages must fill before the strap is trusted
    wire boot_now = !booted && (boot_cnt == `RLM_BOOT_WAIT); // R17
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_cnt <= 2'h0;
            booted <= 1'b0;
        end else begin
            if (!booted)
                boot_cnt <= boot_cnt + 2'h1;
            if (boot_now)
                booted <= 1'b1;
        end
    end

    // strap kept from the boot edge; later switch moves are ignored
    logic startup_strap;
    always_ff @(posedge clk) begin
        if (rst)
            startup_strap <= 1'b0;
        else if (boot_now)
            startup_strap <= sync.startup_mode_select; // R17
    end

    // local button edge detect
    logic button_q;
    always_ff @(posedge clk) begin
        if (rst)
            button_q <= 1'b0;
        else
            button_q <= local_button;
    end
    wire button_press = local_button && !button_q;

    // apb decode
    wire apb_setup = psel && !penable;
    wire apb_access = psel && penable && pready;
    wire apb_wr = apb_access && pwrite;
    wire apb_rd_setup = apb_setup && !pwrite;
    wire hit_ctrl = addr_is(paddr, `RLM_CTRL_ADDR);
    wire hit_status = addr_is(paddr, `RLM_STATUS_ADDR);
    wire hit_ovp = addr_is(paddr, `RLM_OVP_CMD_ADDR);
    wire hit_vset = addr_is(paddr, `RLM_VSET_ADDR);
    wire hit_iset = addr_is(paddr, `RLM_ISET_ADDR);
    wire hit_event = addr_is(paddr, `RLM_EVENT_ADDR);
    wire hit_delay = addr_is(paddr, `RLM_DELAY_ADDR);
    wire hit_flags = addr_is(paddr, `RLM_FLAGS_ADDR);
    // unmapped offsets answer with an error and change nothing
    wire hit_any = hit_ctrl | hit_status | hit_ovp | hit_vset | hit_iset | hit_event | hit_delay | hit_flags;

    wire ev_gtl = apb_wr && hit_event && pwdata[`RLM_EV_GTL];
    wire ev_llo = apb_wr && hit_event && pwdata[`RLM_EV_LLO];
    wire ev_dcl = apb_wr && hit_event && pwdata[`RLM_EV_DCL];
    // any register write except to status, or a gtl or dcl event, counts as a valid bus command
    wire ev_cmd = apb_wr && (hit_any && !hit_status) && !ev_gtl && !ev_dcl;
    wire wr_ctrl = apb_wr && hit_ctrl;

    // mode machine
    rlm_mode_t mode;
    rlm_mode_t next_mode;
    wire ren = sync.remote_enable;
    wire boot_remote = boot_now && !sync.startup_mode_select; // R1
    wire go_remote_from_local = ren && (ev_cmd || ev_llo); // R7

    always_comb begin
        next_mode = mode;
        case (mode)
            RLM_LOCAL: begin
                if (boot_remote || go_remote_from_local)
                    next_mode = ev_llo ? RLM_REMOTE_LOCKED : RLM_REMOTE; // R7
            end
            RLM_REMOTE: begin
                if (!ren || ev_gtl || button_press) // R5
                    next_mode = RLM_LOCAL;
                else if (ev_llo)
                    next_mode = RLM_REMOTE_LOCKED;
            end
            RLM_REMOTE_LOCKED: begin // R6
                if (!ren) // R11
                    next_mode = RLM_LOCAL;
                else if (ev_gtl) // R10
                    next_mode = RLM_LOCAL;
                // button_press has no effect in this state
            end
            default: next_mode = RLM_LOCAL;
        endcase
        if (boot_now && sync.startup_mode_select)
            next_mode = RLM_LOCAL; // R1
    end

    // lockout persists across gtl until ren drops
    logic llo;
    always_ff @(posedge clk) begin
        if (rst)
            llo <= 1'b0; // R18
        else if (!ren)
            llo <= 1'b0; // R11
        else if (ev_llo)
            llo <= 1'b1;
    end

    // re-entry while lockout is remembered lands in the locked state
    always_ff @(posedge clk) begin
        if (rst)
            mode <= RLM_LOCAL; // R18
        else if (next_mode == RLM_REMOTE && llo && mode == RLM_LOCAL)
            mode <= RLM_REMOTE_LOCKED;
        else
            mode <= next_mode;
    end

    wire in_remote = (mode != RLM_LOCAL);
    wire enter_remote = (mode == RLM_LOCAL) && (next_mode != RLM_LOCAL);
    // the startup entry is not a session toggle, so the output stays on
    wire session_entry = enter_remote && !boot_now;
    wire load_defaults = ev_dcl || (boot_now && boot_remote); // R16

    // software settings
    logic [LEVEL_W-1:0] sw_vset;
    logic [LEVEL_W-1:0] sw_iset;
    logic [LEVEL_W-1:0] sw_ovp;
    logic [15:0] sw_delay;
    logic [5:0] ctrl;

    always_ff @(posedge clk) begin
        if (rst) begin
            sw_vset <= '0;
            sw_iset <= '0;
            sw_ovp <= ovp_default(MODEL_VOLTAGE_MAX);
            sw_delay <= DELAY_DEFAULT;
        end else if (load_defaults) begin
            sw_vset <= '0; // R3
            sw_iset <= '0; // R3
            sw_ovp <= ovp_default(MODEL_VOLTAGE_MAX); // R3
            sw_delay <= DELAY_DEFAULT; // R4
        end else begin
            if (apb_wr && hit_vset)
                sw_vset <= pwdata[LEVEL_W-1:0];
            if (apb_wr && hit_iset)
                sw_iset <= pwdata[LEVEL_W-1:0];
            if (apb_wr && hit_ovp)
                sw_ovp <= pwdata[LEVEL_W-1:0];
            if (apb_wr && hit_delay)
                sw_delay <= pwdata[15:0];
        end
    end

    // a ctrl write in the entry cycle wins over the forced output off
    always_ff @(posedge clk) begin
        if (rst)
            ctrl <= `RLM_CTRL_RESET;
        else if (load_defaults)
            ctrl <= `RLM_CTRL_RESET; // R4
        else if (wr_ctrl)
            ctrl <= pwdata[5:0];
        else if (session_entry)
            ctrl[`RLM_CTRL_OUT_ON] <= 1'b0; // R8
    end

    // ovp ownership
    wire ovp_sw_only = local_ovp_jumper && !remote_ovp_jumper;
    wire ovp_follow = local_ovp_jumper && remote_ovp_jumper;
    wire ovp_from_sw = ovp_sw_only || (ovp_follow && in_remote); // R13 R12

    // shutdown: jumper high = default, active-high input
    wire shdn_active = shutdown_polarity_jumper ? sync.shutdown_in : !sync.shutdown_in; // R15
    wire out_allowed = ctrl[`RLM_CTRL_OUT_ON] || !in_remote;

    always_ff @(posedge clk) begin
        if (rst) begin
            remote_indicator <= 1'b0;
            output_enable <= 1'b0;
            voltage_level <= '0;
            current_level <= '0;
            ovp_level <= '0;
        end else begin
            remote_indicator <= in_remote; // R2
            // no output until the boot mode is settled
            output_enable <= booted && out_allowed && !shdn_active; // R14
            voltage_level <= pick_level(in_remote, sw_vset, panel_voltage); // R9
            current_level <= pick_level(in_remote, sw_iset, panel_current); // R9
            ovp_level <= pick_level(ovp_from_sw, sw_ovp, panel_ovp); // R12
        end
    end

    // fixed limits and control flags go straight from registers
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_voltage_limit <= MODEL_VOLTAGE_MAX;
            soft_current_limit <= MODEL_CURRENT_MAX;
            protection_delay <= DELAY_DEFAULT;
            foldback_protection <= 1'b0;
            hold_mode <= 1'b0;
            service_request_enable <= 1'b0;
            aux_output_a <= 1'b0;
            aux_output_b <= 1'b0;
        end else begin
            soft_voltage_limit <= MODEL_VOLTAGE_MAX; // R4
            soft_current_limit <= MODEL_CURRENT_MAX; // R4
            protection_delay <= sw_delay;
            foldback_protection <= ctrl[`RLM_CTRL_FOLDBACK_PROTECTION];
            hold_mode <= ctrl[`RLM_CTRL_HOLD];
            service_request_enable <= ctrl[`RLM_CTRL_SRQ];
            aux_output_a <= ctrl[`RLM_CTRL_AUX_OUTPUT_A];
            aux_output_b <= ctrl[`RLM_CTRL_AUX_OUTPUT_B];
        end
    end

    // apb read path, one wait-free access phase
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0;
        status_word[`RLM_ST_REMOTE] = in_remote;
        status_word[`RLM_ST_LLO] = llo;
        status_word[`RLM_ST_OVP_SW] = ovp_from_sw;
        status_word[`RLM_ST_OUT_EN] = output_enable;
        status_word[`RLM_ST_SHDN] = shdn_active;
        status_word[`RLM_ST_REN] = ren;
        status_word[`RLM_ST_STRAP] = startup_strap;
    end

    wire [31:0] rd_mux =
        hit_ctrl ? {26'h0, ctrl} :
        hit_status ? status_word :
        hit_ovp ? 32'(sw_ovp) :
        hit_vset ? 32'(sw_vset) :
        hit_iset ? 32'(sw_iset) :
        hit_delay ? {16'h0, sw_delay} :
        32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !hit_any;
            // read data is captured in setup so it stands through the access cycle
            if (apb_rd_setup)
                prdata <= rd_mux;
        end
    end
endmodule

// ---- rlm_sva.sv ----
`timescale 1ns/1ns
module rlm_sva #(
    parameter int LEVEL_W = 16,
    parameter logic [LEVEL_W-1:0] MODEL_VOLTAGE_MAX = 16'h7FFF,
    parameter logic [LEVEL_W-1:0] MODEL_CURRENT_MAX = 16'h7FFF
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic remote_enable,
    input wire logic local_ovp_jumper,
    input wire logic shutdown_polarity_jumper,
    input wire logic shutdown_in,
    input wire logic [LEVEL_W-1:0] panel_voltage,
    input wire logic [LEVEL_W-1:0] panel_current,
    input wire logic [LEVEL_W-1:0] panel_ovp,
    input wire logic remote_indicator,
    input wire logic output_enable,
    input wire logic [LEVEL_W-1:0] voltage_level,
    input wire logic [LEVEL_W-1:0] current_level,
    input wire logic [LEVEL_W-1:0] ovp_level,
    input wire logic [LEVEL_W-1:0] soft_voltage_limit,
    input wire logic [LEVEL_W-1:0] soft_current_limit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_local;
        !remote_indicator[*8];
    endsequence
    sequence s_shdn_act;
        (shutdown_in == shutdown_polarity_jumper)[*5];
    endsequence
    a_boot_wait: assert property ($fell(rst) |-> !remote_indicator[*4])
        else $error("indicator lit before boot");
    a_ren_local: assert property (!remote_enable[*8] |-> !remote_indicator)
        else $error("remote kept without ren");
    a_shdn_off: assert property (s_shdn_act |-> !output_enable)
        else $error("output on during shutdown");
    a_shdn_on: assert property ((!remote_indicator && shutdown_in != shutdown_polarity_jumper)[*8] |-> output_enable)
        else $error("local output not restored");
    a_local_lvl: assert property ((!remote_indicator && $stable(panel_voltage) && $stable(panel_current))[*8]
        |-> voltage_level == panel_voltage && current_level == panel_current)
        else $error("local levels not from panel");
    a_entry_off: assert property (s_local ##1 remote_indicator |=> !output_enable[*2])
        else $error("output on after remote entry");
    a_ovp_panel: assert property ((!local_ovp_jumper && $stable(panel_ovp))[*8] |-> ovp_level == panel_ovp)
        else $error("ovp not from panel");
    a_soft_lim: assert property (soft_voltage_limit == MODEL_VOLTAGE_MAX && soft_current_limit == MODEL_CURRENT_MAX)
        else $error("soft limits wrong");
endmodule
bind rlm_top rlm_sva #(.LEVEL_W(LEVEL_W), .MODEL_VOLTAGE_MAX(MODEL_VOLTAGE_MAX),
    .MODEL_CURRENT_MAX(MODEL_CURRENT_MAX)) rlm_sva_inst (.*);

// ---- rlm_host.sv ----
`timescale 1ns/1ns
module rlm_host (
    input wire logic clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic remote_enable
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        remote_enable = 1'h1;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // released lines no longer show the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    task ren(input logic v);
        @(posedge clk);
        remote_enable <= v;
    endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ns
`include "rlm_regs.svh"
module tb_top;
    localparam int OVD = 4096 * `RLM_OVP_PERCENT / `RLM_PERCENT_FULL;
    logic clk = 1'h0, rst = 1'h1, startup_mode_select = 1'h1, local_button = 1'h0;
    logic local_ovp_jumper = 1'h1, remote_ovp_jumper = 1'h1, shutdown_polarity_jumper = 1'h1, shutdown_in = 1'h0;
    logic [15:0] panel_voltage = 16'h0321, panel_current = 16'h0111, panel_ovp = 16'h0777;
    logic psel, penable, pwrite, pready, pslverr, remote_enable, remote_indicator, output_enable;
    logic foldback_protection, hold_mode, service_request_enable, aux_output_a, aux_output_b, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] voltage_level, current_level, ovp_level, soft_voltage_limit, soft_current_limit, protection_delay;
    int mismatches = 0, cmp_count = 0;
    rlm_top #(.MODEL_VOLTAGE_MAX(16'h1000), .MODEL_CURRENT_MAX(16'h0800)) rlm_top_inst (.*);
    rlm_host rlm_host_inst (.*);
    always #4 clk = ~clk;
    task chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, x);
        end
    endtask
    task st;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        rlm_host_inst.xfer(1'h1, a, d, q, e);
        st();
    endtask
    task rd(input logic [11:0] a);
        rlm_host_inst.xfer(1'h0, a, 32'h0, q, e);
    endtask
    task ev(input int b);
        wr(`RLM_EVENT_ADDR, 32'h1 << b);
    endtask
    task press;
        @(posedge clk);
        local_button <= 1'h1;
        repeat (4) @(posedge clk);
        local_button <= 1'h0;
        st();
    endtask
    task do_rst(input logic s);
        @(posedge clk);
        startup_mode_select <= s;
        rst <= 1'h1;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task boot_local;
        do_rst(1'h1);
        chk(remote_indicator, 0);
        chk(voltage_level, panel_voltage);
        chk(output_enable, 1);
        rd(`RLM_STATUS_ADDR);
        chk(q[`RLM_ST_STRAP], 1);
        $display("boot_local done");
    endtask
    task boot_remote;
        do_rst(1'h0);
        chk(remote_indicator, 1);
        chk({voltage_level, current_level}, 0);
        chk(ovp_level, OVD);
        chk(protection_delay, `RLM_DELAY_MS);
        chk({foldback_protection, hold_mode, service_request_enable, aux_output_a, aux_output_b}, 0);
        chk(output_enable, 1);
        chk({soft_voltage_limit, soft_current_limit}, 32'h10000800);
        rd(`RLM_STATUS_ADDR);
        chk(q[`RLM_ST_REMOTE], 1);
        chk(q[`RLM_ST_STRAP], 0);
        rd(12'h020);
        chk(e, 1);
        chk(q, 0);
        $display("boot_remote done");
    endtask
    task t_modes;
        wr(`RLM_OVP_CMD_ADDR, 32'h0123);
        chk(ovp_level, 16'h0123);
        ev(`RLM_EV_GTL);
        chk(remote_indicator, 0);
        chk(ovp_level, panel_ovp);
        ev(`RLM_EV_CMD);
        chk({remote_indicator, output_enable}, 2'h2);
        wr(`RLM_CTRL_ADDR, 32'h1);
        chk(output_enable, 1);
        press();
        chk(remote_indicator, 0);
        $display("t_modes done");
    endtask
    task t_lock;
        ev(`RLM_EV_CMD);
        ev(`RLM_EV_LLO);
        press();
        chk(remote_indicator, 1);
        ev(`RLM_EV_GTL);
        chk(remote_indicator, 0);
        ev(`RLM_EV_CMD);
        press();
        chk(remote_indicator, 1);
        rlm_host_inst.ren(1'h0);
        st();
        st();
        chk(remote_indicator, 0);
        rd(`RLM_STATUS_ADDR);
        chk(q[`RLM_ST_LLO], 0);
        rlm_host_inst.ren(1'h1);
        st();
        ev(`RLM_EV_CMD);
        press();
        chk(remote_indicator, 0);
        $display("t_lock done");
    endtask
    task t_ovp;
        @(posedge clk);
        remote_ovp_jumper <= 1'h0;
        st();
        chk(ovp_level, 16'h0123);
        @(posedge clk);
        local_ovp_jumper <= 1'h0;
        remote_ovp_jumper <= 1'h1;
        ev(`RLM_EV_CMD);
        chk(ovp_level, panel_ovp);
        @(posedge clk);
        local_ovp_jumper <= 1'h1;
        $display("t_ovp done");
    endtask
    task t_shdn;
        wr(`RLM_CTRL_ADDR, 32'h1);
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk);
            shutdown_polarity_jumper <= i[0];
            shutdown_in <= i[0];
            st();
            chk(output_enable, 0);
            @(posedge clk);
            shutdown_in <= ~i[0];
            st();
            chk(output_enable, 1);
        end
        @(posedge clk);
        shutdown_polarity_jumper <= 1'h1;
        shutdown_in <= 1'h0;
        $display("t_shdn done");
    endtask
    task t_dcl;
        wr(`RLM_VSET_ADDR, 32'h0055);
        wr(`RLM_DELAY_ADDR, 32'h0010);
        wr(`RLM_CTRL_ADDR, 32'h3F);
        chk({foldback_protection, hold_mode, service_request_enable, aux_output_a, aux_output_b}, 5'h1F);
        ev(`RLM_EV_DCL);
        chk({foldback_protection, hold_mode, service_request_enable, aux_output_a, aux_output_b}, 0);
        chk({voltage_level, protection_delay}, {16'h0, 16'(`RLM_DELAY_MS)});
        chk({ovp_level, 15'h0, output_enable}, {16'(OVD), 16'h1});
        $display("t_dcl done");
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        boot_local();
        boot_remote();
        t_modes();
        t_lock();
        t_ovp();
        t_shdn();
        t_dcl();
        give_verdict();
    end
endmodule
